// >>> src/tvs_sequencer.sv
// test vector sequencer core with its ahb-lite register slave
//
// Added by the designer: the AHB-Lite register port and the register offsets.
module tvs_sequencer
	import tvs_pkg::*;
#(
	parameter int STEPS = tvs_pkg::TVS_STEPS
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [tvs_pkg::TVS_PINS-1:0] pin_in,
	output logic [tvs_pkg::TVS_PINS-1:0] pin_out,
	output logic [tvs_pkg::TVS_PINS-1:0] pin_oe_n,
	output logic [7:0] ttl_trig_n,
	output logic [1:0] ecl_trig,
	output logic test_fail,
	output logic running
);
	import tvs_pkg::*;

	typedef struct packed {
		tvs_state_t st;
		logic a_wr;
		logic [7:0] a_off;
		logic [31:0] rdata;
		logic one_step_mode;
		logic learn;
		logic [3:0] trigger_line_select;
		logic [13:0] first_step_set;
		logic [13:0] final_step_set;
		logic final_ok;
		logic [13:0] edit;
		logic [13:0] cur;
		logic [15:0] div;
		tvs_step_t step;
		logic fail;
		logic fail_ok;
		logic [13:0] fail_step;
	} tvs_core_t;

	tvs_core_t r;
	tvs_core_t next_r;

	logic tick;
	logic mem_we;
	logic [TVS_STEP_W-1:0] mem_mask;
	logic [13:0] mem_waddr;
	tvs_step_t mem_wdata;
	tvs_step_t mem_rdata;
	logic [TVS_PINS-1:0] mism;
	logic [4*TVS_PINS-1:0] learn_codes;
	logic addr_ph;
	logic wr_hit;
	logic is_final;
	logic trig_on;
	logic [13:0] adv_off;
	logic [13:0] next_step_idx;

	initial
	begin
		if (STEPS < 2 || STEPS > 2**TVS_AW) $error("step count out of range");
	end

	tvs_step_mem #(
		.W(TVS_STEP_W),
		.DEPTH(STEPS),
		.AW(TVS_AW)
	) u_mem (
		.ref_clk(ref_clk),
		.we(mem_we),
		.wmask(mem_mask),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(r.cur),
		.rdata(mem_rdata)
	);

	// the test clock only runs while a step is being applied
	tvs_tick #(
		.DW(16)
	) u_tick (
		.ref_clk(ref_clk),
		.srst(srst),
		.run(r.st == TVS_RUN),
		.period(r.div),
		.tick(tick)
	);

	// per-pin decode of the applied step: drive, enable and compare result
	genvar gi;
	generate
		for (gi = 0; gi < TVS_PINS; gi++)
		begin : g_pin
			tvs_code_t code;
			assign code = tvs_code_t'(r.step.step_pin_data[4*gi +: 4]);
			// codes outside the table act as driver off, as blanks do
			assign pin_out[gi] = (code == TVS_PC_HI) || (code == TVS_PC_BOTH_HI);
			assign pin_oe_n[gi] = !((code == TVS_PC_LO) || (code == TVS_PC_HI) ||
				(code == TVS_PC_BOTH_LO) || (code == TVS_PC_BOTH_HI));
			assign mism[gi] = ((code == TVS_PC_CMP_LO || code == TVS_PC_BOTH_LO) && pin_in[gi]) ||
				((code == TVS_PC_CMP_HI || code == TVS_PC_BOTH_HI) && !pin_in[gi]);
			// learn capture stores what the pin showed as a compare code
			assign learn_codes[4*gi +: 4] = pin_in[gi] ? TVS_PC_CMP_HI : TVS_PC_CMP_LO;
		end
	endgenerate

	// trigger out: ttl lines pull low, ecl lines go high
	assign trig_on = r.step.step_trigger_flag && (r.st == TVS_RUN);
	always_comb
	begin
		ttl_trig_n = 8'hFF;
		ecl_trig = 2'h0;
		if (trig_on && !r.trigger_line_select[3]) ttl_trig_n[r.trigger_line_select[2:0]] = 1'b0;
		if (trig_on && r.trigger_line_select[3]) ecl_trig[r.trigger_line_select[0]] = 1'b1;
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r.rdata;
	assign test_fail = r.fail;
	assign running = (r.st != TVS_IDLE);

	assign addr_ph = hsel && hready && htrans[1];
	assign wr_hit = r.a_wr;
	assign is_final = r.final_ok && (r.cur == r.final_step_set);
	// zero offset stands for the default step of one
	assign adv_off = (hwdata == 32'h0) ? 14'h0001 : hwdata[13:0];
	assign next_step_idx = (r.cur == 14'(STEPS - 1)) ? 14'h0000 : r.cur + 14'h0001;

	// memory write port: learn capture in run, otherwise bus writes at the edit pointer
	always_comb
	begin
		mem_we = 1'b0;
		mem_mask = '0;
		mem_waddr = r.edit;
		mem_wdata = '0;
		if (r.st == TVS_RUN && tick && r.learn)
		begin
			mem_we = !is_final;
			mem_waddr = r.cur;
			mem_mask[4*TVS_PINS-1:0] = '1;
			mem_wdata.step_pin_data = learn_codes;
		end
		else if (wr_hit && (r.a_off == TVS_PIN_DATA || r.a_off == TVS_PIN_DATA_ADV))
		begin
			mem_we = 1'b1;
			mem_mask[4*TVS_PINS-1:0] = '1;
			mem_wdata.step_pin_data = hwdata[4*TVS_PINS-1:0];
		end
		else if (wr_hit && r.a_off == TVS_FLAGS)
		begin
			mem_we = 1'b1;
			mem_mask[TVS_STEP_W-1 -: 3] = 3'h7;
			mem_wdata.step_halt_flag = hwdata[TVS_F_HALT];
			mem_wdata.step_trigger_flag = hwdata[TVS_F_TRIG];
			mem_wdata.verdict_reset_flag = hwdata[TVS_F_CLEAR];
		end
	end

	// all next-state logic: bus slave, register writes, sequencing
	always_comb
	begin
		next_r = r;
		next_r.a_wr = 1'b0;
		// address phase: capture write target, prepare read data at once
		if (addr_ph)
		begin
			next_r.a_wr = hwrite;
			next_r.a_off = haddr[7:0];
			next_r.rdata = 32'h0;
			if (haddr[31:8] == 24'h0 && !hwrite)
			begin
				case (haddr[7:0])
					TVS_MODE:
					begin
						next_r.rdata[TVS_M_ONE_STEP] = r.one_step_mode;
						next_r.rdata[TVS_M_LEARN] = r.learn;
						next_r.rdata[TVS_M_TRIG_LSB +: 4] = r.trigger_line_select;
					end
					TVS_FIRST: next_r.rdata[13:0] = r.first_step_set;
					TVS_FINAL: next_r.rdata = r.final_ok ? {18'h0, r.final_step_set} : 32'hFFFFFFFF;
					TVS_EDIT: next_r.rdata[13:0] = r.edit;
					TVS_TICK_DIV: next_r.rdata[15:0] = r.div;
					TVS_STATUS:
					begin
						next_r.rdata[13:0] = r.cur;
						next_r.rdata[TVS_S_STATE_LSB +: 6] = r.st;
						next_r.rdata[TVS_S_FAIL] = r.fail;
						next_r.rdata[TVS_S_FAIL_OK] = r.fail_ok;
					end
					TVS_FAIL_STEP: next_r.rdata[13:0] = r.fail_step;
					default: next_r.rdata = 32'h0;
				endcase
			end
		end

		// data phase of a write; unmapped offsets are ignored
		if (wr_hit)
		begin
			case (r.a_off)
				TVS_MODE:
				begin
					next_r.one_step_mode = hwdata[TVS_M_ONE_STEP];
					next_r.learn = hwdata[TVS_M_LEARN];
					next_r.trigger_line_select = hwdata[TVS_M_TRIG_LSB +: 4];
				end
				TVS_FIRST: next_r.first_step_set = (hwdata < 32'(STEPS)) ? hwdata[13:0] : r.first_step_set;
				TVS_FINAL:
				begin
					// values beyond the last legal step leave no valid final step
					next_r.final_ok = (hwdata <= 32'(TVS_FINAL_MAX)) && (hwdata < 32'(STEPS));
					next_r.final_step_set = hwdata[13:0];
				end
				TVS_EDIT: next_r.edit = hwdata[13:0];
				TVS_EDIT_ADV: next_r.edit = r.edit + adv_off;
				TVS_PIN_DATA_ADV: next_r.edit = r.edit + 14'h0001;
				TVS_TICK_DIV: next_r.div = hwdata[15:0];
				default: next_r.edit = r.edit;
			endcase
		end

		// sequencer state machine
		case (r.st)
			TVS_IDLE:
			begin
				if (wr_hit && r.a_off == TVS_CTRL && hwdata[TVS_C_ARM]) next_r.st = TVS_ARMED;
			end
			TVS_ARMED:
			begin
				// start counts only once armed
				if (wr_hit && r.a_off == TVS_CTRL && hwdata[TVS_C_START])
				begin
					next_r.st = TVS_LOAD;
					next_r.cur = r.first_step_set;
					next_r.fail = 1'b0;
					next_r.fail_ok = 1'b0;
				end
			end
			TVS_LOAD: next_r.st = TVS_FETCH;
			TVS_FETCH:
			begin
				// step takes effect: pins, trigger and clear
				next_r.step = mem_rdata;
				next_r.st = TVS_RUN;
				if (mem_rdata.verdict_reset_flag)
				begin
					next_r.fail = 1'b0;
					next_r.fail_ok = 1'b0;
				end
			end
			TVS_RUN:
			begin
				if (tick)
				begin
					// compares are judged at the end of the step
					if (|mism)
					begin
						next_r.fail = 1'b1;
						if (!r.fail_ok)
						begin
							next_r.fail_ok = 1'b1;
							next_r.fail_step = r.cur;
						end
					end
					if (is_final) next_r.st = TVS_IDLE;
					else if (r.step.step_halt_flag || r.one_step_mode) next_r.st = TVS_PAUSED;
					else
					begin
						next_r.cur = next_step_idx;
						next_r.st = TVS_LOAD;
					end
				end
			end
			TVS_PAUSED:
			begin
				if (wr_hit && r.a_off == TVS_CTRL && hwdata[TVS_C_RESUME])
				begin
					next_r.cur = next_step_idx;
					next_r.st = TVS_LOAD;
				end
			end
			default: next_r.st = TVS_IDLE;
		endcase

		// stop ends any run; pins keep the last applied step
		if (wr_hit && r.a_off == TVS_CTRL && hwdata[TVS_C_STOP]) next_r.st = TVS_IDLE;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			r <= '0;
			r.st <= TVS_IDLE;
			r.first_step_set <= TVS_FIRST_RST;
			r.div <= TVS_DIV_RST;
		end
		else
		begin
			r <= next_r;
		end
	end
endmodule : tvs_sequencer

// >>> src/tvs_pkg.sv
// shared constants and types of the test vector sequencer
package tvs_pkg;
	localparam int TVS_PINS = 8;
	localparam int TVS_AW = 14;
	localparam int TVS_STEPS = 16351;
	localparam logic [13:0] TVS_FINAL_MAX = 14'h3FDE;
	localparam logic [13:0] TVS_FIRST_RST = 14'h0000;
	localparam logic [15:0] TVS_DIV_RST = 16'h0009;
	localparam int TVS_FAIL_TAIL = 5;
	// byte offsets of the register words
	localparam logic [7:0] TVS_CTRL = 8'h00;
	localparam logic [7:0] TVS_MODE = 8'h04;
	localparam logic [7:0] TVS_FIRST = 8'h08;
	localparam logic [7:0] TVS_FINAL = 8'h0C;
	localparam logic [7:0] TVS_EDIT = 8'h10;
	localparam logic [7:0] TVS_EDIT_ADV = 8'h14;
	localparam logic [7:0] TVS_PIN_DATA = 8'h18;
	localparam logic [7:0] TVS_PIN_DATA_ADV = 8'h1C;
	localparam logic [7:0] TVS_FLAGS = 8'h20;
	localparam logic [7:0] TVS_TICK_DIV = 8'h24;
	localparam logic [7:0] TVS_STATUS = 8'h28;
	localparam logic [7:0] TVS_FAIL_STEP = 8'h2C;
	// control, mode, flag and status word bits
	localparam int TVS_C_ARM = 0;
	localparam int TVS_C_START = 1;
	localparam int TVS_C_STOP = 2;
	localparam int TVS_C_RESUME = 3;
	localparam int TVS_M_ONE_STEP = 0;
	localparam int TVS_M_LEARN = 1;
	localparam int TVS_M_TRIG_LSB = 4;
	localparam int TVS_F_HALT = 0;
	localparam int TVS_F_TRIG = 1;
	localparam int TVS_F_CLEAR = 2;
	localparam int TVS_S_STATE_LSB = 16;
	localparam int TVS_S_FAIL = 24;
	localparam int TVS_S_FAIL_OK = 25;

	// four-bit pin codes; zero means driver off so unwritten pins float
	typedef enum logic [3:0] {
		TVS_PC_OFF = 4'h0,
		TVS_PC_LO = 4'h1,
		TVS_PC_HI = 4'h2,
		TVS_PC_CMP_LO = 4'h3,
		TVS_PC_CMP_HI = 4'h4,
		TVS_PC_BOTH_LO = 4'h5,
		TVS_PC_BOTH_HI = 4'h6
	} tvs_code_t;

	typedef enum logic [5:0] {
		TVS_IDLE = 6'h01,
		TVS_ARMED = 6'h02,
		TVS_LOAD = 6'h04,
		TVS_FETCH = 6'h08,
		TVS_RUN = 6'h10,
		TVS_PAUSED = 6'h20
	} tvs_state_t;

	// one stored step: flags above the pin codes
	typedef struct packed {
		logic verdict_reset_flag;
		logic step_trigger_flag;
		logic step_halt_flag;
		logic [4*TVS_PINS-1:0] step_pin_data;
	} tvs_step_t;

	localparam int TVS_STEP_W = $bits(tvs_step_t);
endpackage : tvs_pkg

// >>> src/tvs_step_mem.sv
// step memory with a bit write mask and registered read data
module tvs_step_mem #(
	parameter int W = 35,
	parameter int DEPTH = 16351,
	parameter int AW = 14
) (
	input wire logic ref_clk,
	input wire logic we,
	input wire logic [W-1:0] wmask,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [DEPTH];

	initial
	begin
		if (DEPTH > 2**AW) $error("depth does not fit the address");
	end

	// masked write lets flags and pin codes be written separately
	always_ff @(posedge ref_clk)
	begin
		// one extra bit keeps a full-size memory from comparing against zero
		if (we && ({1'b0, waddr} < (AW+1)'(DEPTH)))
		begin
			for (int i = 0; i < W; i++)
			begin
				if (wmask[i]) mem[waddr][i] <= wdata[i];
			end
		end
		rdata <= mem[raddr];
	end
endmodule : tvs_step_mem

// >>> src/tvs_tick.sv
// test clock divider: one-cycle tick every period+1 cycles while run is high
module tvs_tick #(
	parameter int DW = 16
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic run,
	input wire logic [DW-1:0] period,
	output logic tick
);
	typedef struct packed {
		logic [DW-1:0] cnt;
	} tvs_tick_st_t;

	tvs_tick_st_t r;
	tvs_tick_st_t next_r;

	initial
	begin
		if (DW < 1 || DW > 32) $error("divider width out of range");
	end

	// counter restarts whenever run drops, so every step gets a full period
	always_comb
	begin
		next_r = r;
		if (!run || r.cnt >= period) next_r.cnt = '0;
		else next_r.cnt = r.cnt + 1'b1;
	end

	assign tick = run && (r.cnt >= period);

	always_ff @(posedge ref_clk)
	begin
		if (srst) r <= '0;
		else r <= next_r;
	end
endmodule : tvs_tick

// >>> dv/tvs_dut_pins.sv
// behavioural model of the device-under-test pins facing the sequencer
module tvs_dut_pins
	import tvs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [tvs_pkg::TVS_PINS-1:0] pin_out,
	input wire logic [tvs_pkg::TVS_PINS-1:0] pin_oe_n,
	output logic [tvs_pkg::TVS_PINS-1:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// released pins follow a counter stepped every cycle so a stale level never passes a compare;
	// bit 0 stays low, the device holds pin 0 low so a compare-high there fails
	logic [TVS_PINS-1:0] wander = '0;
	always @(posedge ref_clk)
		wander <= wander + TVS_PINS'(2);
	// a driven pin reads back its own level
	assign pin_in = (pin_out & ~pin_oe_n) | (wander & pin_oe_n);
endmodule : tvs_dut_pins

// >>> dv/tvs_sequencer_asserts.sv
// port-level assertions of the test vector sequencer, bound into its top
module tvs_sequencer_asserts #(
	parameter int STEPS = 16351
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] ttl_trig_n,
	input wire logic [1:0] ecl_trig,
	input wire logic test_fail,
	input wire logic running
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	// zero wait states and an okay response at every edge
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or answered with an error");
	// first edge after reset: pins off, triggers idle, pass, idle
	AST_RESET_QUIET: assert property ($fell(srst) |-> (pin_oe_n == 8'hFF && ttl_trig_n == 8'hFF
		&& ecl_trig == 2'h0 && !test_fail && !running))
		else $error("outputs not quiet after reset");
	AST_TRIG_ONE: assert property ($countones(~ttl_trig_n) + $countones(ecl_trig) <= 1)
		else $error("more than one trigger line asserted");
	AST_TRIG_RUN: assert property ((ttl_trig_n != 8'hFF || ecl_trig != 2'h0) |-> running)
		else $error("trigger asserted while the sequencer is idle");
	AST_PINS_HOLD: assert property (!running && !$past(running) |->
		$stable(pin_out) && $stable(pin_oe_n))
		else $error("pins moved while stopped");
	AST_FAIL_RISE: assert property ($rose(test_fail) |-> $past(running))
		else $error("fail state set outside a run");
	AST_FAIL_FALL: assert property ($fell(test_fail) |-> $past(running))
		else $error("fail state cleared outside a run");
	// a step lasts at least one run cycle plus the load and fetch cycles
	AST_STEP_MIN: assert property (($changed(pin_oe_n) || $changed(pin_out)) |=>
		($stable(pin_oe_n) && $stable(pin_out)) [*2])
		else $error("pins changed twice within one step");
endmodule : tvs_sequencer_asserts

bind tvs_sequencer tvs_sequencer_asserts #(.STEPS(STEPS)) chk_u (
	.ref_clk(ref_clk),
	.srst(srst),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.pin_out(pin_out),
	.pin_oe_n(pin_oe_n),
	.ttl_trig_n(ttl_trig_n),
	.ecl_trig(ecl_trig),
	.test_fail(test_fail),
	.running(running)
);

// >>> dv/tvs_sequencer_tb.sv
// self-checking testbench of the test vector sequencer
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tvs_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import tvs_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hready, hreadyout, hresp, test_fail, running;
	logic [31:0] hrdata, rd;
	logic [7:0] pin_in, pin_out, pin_oe_n, ttl_trig_n;
	logic [1:0] ecl_trig;
	logic [9:0] exp_trig;
	logic [31:0] cd [2:10];
	int bad_count = 0;
	int samples_checked = 0;
	int seed = 44038;
	int tcnt = 0;
	assign hready = hreadyout;
	tvs_sequencer dut_u (.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ttl_trig_n(ttl_trig_n),
		.ecl_trig(ecl_trig), .test_fail(test_fail), .running(running));
	tvs_dut_pins pins_u (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pin_in(pin_in));
	initial
	begin
		forever #50 ref_clk = ~ref_clk;
	end
	// counts cycles in which exactly the expected trigger line is asserted
	always @(posedge ref_clk)
		if ({ttl_trig_n, ecl_trig} === exp_trig)
			tcnt++;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	// one single ahb-lite transfer, waits bounded on hready in both phases
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		n = 0;
		do begin @(posedge ref_clk); n++; end while (hready !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge ref_clk); n++; end while (hready !== 1'b1 && n < 100);
		rd = hrdata;
		if (n >= 100)
		begin
			bad_count++;
			finish_test();
		end
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, {24'h0, a}, d);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, {24'h0, a}, 32'h0);
		`CHK(rd, e)
	endtask : rd_chk
	task automatic wait_state(input logic [5:0] s);
		for (int k = 0; k < 200; k++)
		begin
			xfer(1'b0, {24'h0, TVS_STATUS}, 32'h0);
			if (rd[21:16] === s)
				return;
		end
		bad_count++;
		finish_test();
	endtask : wait_state
	// expected {oe_n, out} of a step's eight pin codes
	function automatic logic [15:0] pins_exp(input logic [31:0] c);
		logic [7:0] oe_n, out;
		logic [3:0] n;
		for (int i = 0; i < 8; i++)
		begin
			n = c[4*i+:4];
			oe_n[i] = !(n == 4'h1 || n == 4'h2 || n == 4'h5 || n == 4'h6);
			out[i] = (n == 4'h2 || n == 4'h6);
		end
		return {oe_n, out};
	endfunction : pins_exp
	task automatic check_pins(input logic [31:0] c);
		logic [15:0] e;
		e = pins_exp(c);
		`CHK(pin_oe_n, e[15:8])
		`CHK(pin_out & ~e[15:8], e[7:0] & ~e[15:8])
	endtask : check_pins
	// one run from arm to the first pause, trigger counted on the given line
	task automatic arm_start(input logic [31:0] mode, input logic [9:0] trig);
		wr(TVS_MODE, mode);
		exp_trig = trig;
		tcnt = 0;
		wr(TVS_CTRL, 32'h1);
		wr(TVS_CTRL, 32'h2);
		wait_state(6'h20);
	endtask : arm_start
	initial
	begin
		exp_trig = 10'h3FF;
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rd_chk(TVS_FIRST, 32'h0);
		rd_chk(TVS_FINAL, 32'hFFFFFFFF);
		xfer(1'b0, 32'h0000_0100, 32'h0);
		`CHK(rd, 32'h0)
		wr(TVS_FINAL, 32'd16350);
		rd_chk(TVS_FINAL, 32'd16350);
		wr(TVS_FINAL, 32'd16351);
		rd_chk(TVS_FINAL, 32'hFFFFFFFF);
		// random drive codes; step 2 compares pin 0 high against a low pin
		for (int i = 2; i <= 10; i++)
			for (int j = 0; j < 8; j++)
				cd[i][4*j+:4] = 4'($unsigned($random(seed)) % 3);
		cd[2][3:0] = 4'h4;
		// pin 0 of step 7 driven, so an overwrite by learned compare codes shows
		cd[7][3:0] = 4'h1;
		wr(TVS_EDIT, 32'h2);
		for (int i = 2; i <= 10; i++)
			wr(TVS_PIN_DATA_ADV, cd[i]);
		rd_chk(TVS_EDIT, 32'd11);
		wr(TVS_EDIT, 32'h3);
		wr(TVS_FLAGS, 32'h3);
		wr(TVS_EDIT_ADV, 32'h0);
		rd_chk(TVS_EDIT, 32'h4);
		wr(TVS_FLAGS, 32'h4);
		wr(TVS_EDIT_ADV, 32'h3FFC);
		rd_chk(TVS_EDIT, 32'h0);
		wr(TVS_FIRST, 32'h2);
		wr(TVS_FINAL, 32'd10);
		wr(TVS_TICK_DIV, 32'h1);
		// free run on ecl line 0, halts on step 3 with the fail latched
		arm_start(32'h80, {8'hFF, 2'h1});
		rd_chk(TVS_STATUS, 32'h0320_0003);
		`CHK(test_fail, 1'b1)
		`CHK(tcnt, 2)
		check_pins(cd[3]);
		wr(TVS_CTRL, 32'h8);
		wait_state(6'h01);
		rd_chk(TVS_STATUS, 32'h0001_000A);
		check_pins(cd[10]);
		// one-step mode set before arming, ttl line 2, low while asserted
		arm_start(32'h21, {8'hFB, 2'h0});
		rd_chk(TVS_STATUS, 32'h0320_0002);
		check_pins(cd[2]);
		wr(TVS_CTRL, 32'h8);
		wait_state(6'h20);
		rd_chk(TVS_STATUS, 32'h0320_0003);
		`CHK(tcnt, 2)
		wr(TVS_CTRL, 32'h4);
		wait_state(6'h01);
		`CHK(running, 1'b0)
		check_pins(cd[3]);
		// learn run over steps 5..7, then replay step 7 alone: it must be unchanged
		wr(TVS_MODE, 32'h2);
		wr(TVS_FIRST, 32'h5);
		wr(TVS_FINAL, 32'h7);
		wr(TVS_CTRL, 32'h1);
		wr(TVS_CTRL, 32'h2);
		wait_state(6'h01);
		wr(TVS_MODE, 32'h0);
		wr(TVS_FIRST, 32'h7);
		wr(TVS_CTRL, 32'h1);
		wr(TVS_CTRL, 32'h2);
		wait_state(6'h01);
		check_pins(cd[7]);
		finish_test();
	end
endmodule : tvs_sequencer_tb
